// ==== hw/cs_core.sv ====
// Core state of the CPU: flags, register file, stack pointer, entry.
// Assumes an outside sequencer reports each finished instruction once
// and that data memory answers reads in the same cycle.
//
// Overview of operation
// - Bit store and bit load use bit six.
// - Bit five flags carry out of low nibble.
// - Sign flag always equals negative xor overflow.
// - Negative bit two, zero bit one.
// - Carry bit zero, overflow bit three.
// - Register file offers byte and pair ports.
// - Registers appear at data addresses zero to 1f.
// - Top six registers form three pointer pairs.
// - Stack grows down, one or two bytes.
// - Stack pointer in two resettable I/O bytes.
// - Undivided clock, one-cycle ALU write-back.
// - Taking needs individual and global enables.
// - Boot lock bits suppress interrupts by PC.
// - Lower vector index wins priority.
// - Vector select relocates vectors; fuse relocates reset.
// - Entry clears global enable; return sets it.
// - Event flags clear on vectoring or write-one.
// - Level requests exist only while condition holds.
// - One main instruction runs after each return.
// - Status is never saved or restored automatically.
// - Disable instruction blocks even simultaneous interrupts.
// - Entry four cycles pushing PC; return three.
// - Instruction after enable runs before interrupts.
`timescale 1ns/1ps
module cs_core #(
    parameter int NUM_IRQ = 8,
    parameter logic [NUM_IRQ-1:0] LEVEL_MASK = '0,
    parameter int PC_W = 13,
    parameter logic [PC_W-1:0] BOOT_START = '1,
    parameter int VEC_WORDS = 2
) (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Instruction completion
    input wire logic exec_valid,
    input wire cs_pkg::cs_op_e exec_op,
    input wire logic [4:0] exec_rd,
    input wire logic [4:0] exec_rr,
    input wire logic [7:0] exec_imm,
    input wire logic [2:0] exec_bit,
    input wire logic [1:0] exec_ptr,
    input wire cs_pkg::cs_ptr_mode_e exec_ptr_mode,
    input wire logic [5:0] exec_disp,
    output logic exec_ready,
    // Status register access
    input wire logic status_we,
    input wire logic [7:0] status_wdata,
    output logic [7:0] status_flags,
    // I/O register access
    input wire logic [5:0] io_addr,
    input wire logic io_we,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    output logic io_hit,
    // Data memory
    output logic [15:0] mem_addr,
    output logic mem_we,
    output logic mem_re,
    output logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata,
    // Interrupt sources
    input wire logic [NUM_IRQ-1:0] irq_event,
    input wire logic [NUM_IRQ-1:0] irq_level,
    input wire logic [NUM_IRQ-1:0] irq_enable,
    input wire logic [NUM_IRQ-1:0] irq_flag_clear,
    output logic [NUM_IRQ-1:0] irq_pending,
    // Boot configuration
    input wire logic vector_select_bit,
    input wire logic boot_reset_fuse,
    input wire logic app_section_lock_bit,
    input wire logic boot_section_lock_bit,
    input wire logic pc_in_boot,
    // Program counter
    input wire logic [PC_W-1:0] ret_pc,
    output logic pc_load,
    output logic [PC_W-1:0] pc_value,
    output logic [PC_W-1:0] reset_vector
);
    import cs_pkg::*;

    localparam int IDX_W = (NUM_IRQ > 1) ? $clog2(NUM_IRQ) : 1;

    function automatic cs_alu_s cs_alu8(input cs_op_e op,
        input logic [7:0] a, input logic [7:0] b, input logic cin,
        input logic zin);
        cs_alu_s o;
        logic [7:0] r;
        o = '0;
        case (op)
            OP_ADD: r = a + b;
            OP_ADC: r = a + b + {7'h00, cin};
            OP_SUB: r = a - b;
            OP_SBC: r = a - b - {7'h00, cin};
            OP_AND: r = a & b;
            OP_OR: r = a | b;
            OP_EOR: r = a ^ b;
            default: r = a;
        endcase
        o.res = r;
        o.n = r[7];
        o.z = (r == 8'h00) && ((op != OP_SBC) || zin);
        if (op == OP_SUB || op == OP_SBC)
        begin
            o.c = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
            o.h = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
            o.v = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
        end
        else
        begin
            o.c = (a[7] & b[7]) | (b[7] & ~r[7]) | (~r[7] & a[7]);
            o.h = (a[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & a[3]);
            o.v = (a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]);
        end
        return o;
    endfunction : cs_alu8

    function automatic logic [PAIR_AW-1:0] cs_ptr_pair(
        input logic [1:0] sel);
        case (sel)
            2'h1: return PTR_SECOND_LOW[REG_AW-1:1];
            2'h2: return PTR_THIRD_LOW[REG_AW-1:1];
            default: return PTR_FIRST_LOW[REG_AW-1:1];
        endcase
    endfunction : cs_ptr_pair

    function automatic logic [IDX_W-1:0] cs_first(
        input logic [NUM_IRQ-1:0] r);
        logic [IDX_W-1:0] k;
        k = '0;
        for (int i = NUM_IRQ - 1; i >= 0; i--)
        begin
            if (r[i])
            begin
                k = IDX_W'(i);
            end
        end
        return k;
    endfunction : cs_first

    cs_rf_if rf ();
    cs_regfile u_rf (
        .clock(clock),
        .port(rf.rf)
    );

    cs_state_e state_q;
    logic [7:0] status_q;
    logic [15:0] sp_q;
    logic [NUM_IRQ-1:0] pend_q;
    logic inhibit_q;
    logic [PC_W-1:0] ret_pc_q;
    logic [PC_W-1:0] vec_q;
    logic [7:0] pop_hi_q;
    logic [PC_W-1:0] popped_pc_q;

    logic fetch;
    logic [7:0] op_a;
    cs_alu_s alu;
    logic [15:0] adiw_sum;
    logic [15:0] ptr_new;
    logic [15:0] eff_addr;
    logic reg_hit;
    logic [15:0] sp_addr;
    logic [15:0] sp_plus1;
    logic [15:0] ret_word;
    logic [NUM_IRQ-1:0] req;
    logic [IDX_W-1:0] win_idx;
    logic [NUM_IRQ-1:0] ack;
    logic gie_now;
    logic suppress;
    logic take;

    assign exec_ready = (state_q == ST_RUN);
    assign fetch = exec_valid && exec_ready;

    assign rf.ra_addr = exec_rd;
    assign rf.rb_addr = exec_rr;
    assign op_a = rf.ra_data;
    assign alu = cs_alu8(exec_op, op_a, rf.rb_data, status_q[FLAG_C],
                         status_q[FLAG_Z]);
    assign adiw_sum = rf.pr_data + {10'h000, exec_imm[5:0]};

    assign rf.pr_addr = (exec_op == OP_MOVW) ? exec_rr[4:1] :
                        (exec_op == OP_ADIW) ? exec_rd[4:1] :
                        cs_ptr_pair(exec_ptr);
    always_comb
    begin
        ptr_new = rf.pr_data;
        eff_addr = rf.pr_data;
        case (exec_ptr_mode)
            PM_POST_INC: ptr_new = rf.pr_data + SP_STEP_ONE;
            PM_PRE_DEC:
            begin
                ptr_new = rf.pr_data - SP_STEP_ONE;
                eff_addr = ptr_new;
            end
            PM_DISP: eff_addr = rf.pr_data + {10'h000, exec_disp};
            default: ptr_new = rf.pr_data;
        endcase
    end
    assign reg_hit = (eff_addr <= REG_SPACE_TOP);
    assign rf.ds_addr = eff_addr[REG_AW-1:0];

    always_comb
    begin
        rf.w8_en = 1'b0;
        rf.w8_addr = exec_rd;
        rf.w8_data = alu.res;
        rf.w16_en = 1'b0;
        rf.w16_addr = exec_rd[4:1];
        rf.w16_data = adiw_sum;
        if (fetch)
        begin
            case (exec_op)
                OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_AND, OP_OR, OP_EOR:
                    rf.w8_en = 1'b1;
                OP_LDI:
                begin
                    rf.w8_en = 1'b1;
                    rf.w8_data = exec_imm;
                end
                OP_BLD:
                begin
                    rf.w8_en = 1'b1;
                    rf.w8_data = op_a;
                    rf.w8_data[exec_bit] = status_q[FLAG_T];
                end
                OP_POP:
                begin
                    rf.w8_en = 1'b1;
                    rf.w8_data = mem_rdata;
                end
                OP_ADIW: rf.w16_en = 1'b1;
                OP_MOVW:
                begin
                    rf.w16_en = 1'b1;
                    rf.w16_data = rf.pr_data;
                end
                OP_LD, OP_ST:
                begin
                    rf.w8_en = (exec_op == OP_LD) || reg_hit;
                    rf.w8_addr = (exec_op == OP_LD) ? exec_rd : rf.ds_addr;
                    rf.w8_data = (exec_op == OP_ST) ? op_a :
                                 reg_hit ? rf.ds_data : mem_rdata;
                    rf.w16_en = (exec_ptr_mode == PM_POST_INC) ||
                                (exec_ptr_mode == PM_PRE_DEC);
                    rf.w16_addr = cs_ptr_pair(exec_ptr);
                    rf.w16_data = ptr_new;
                end
                default: rf.w8_en = 1'b0;
            endcase
        end
    end

    assign sp_addr = {{(16 - SP_W){1'b0}}, sp_q[SP_W-1:0]};
    assign sp_plus1 = {{(16 - SP_W){1'b0}}, sp_q[SP_W-1:0] +
                       SP_STEP_ONE[SP_W-1:0]};
    assign ret_word = {{(16 - PC_W){1'b0}}, ret_pc_q};
    always_comb
    begin
        mem_addr = sp_addr;
        mem_we = 1'b0;
        mem_re = 1'b0;
        mem_wdata = ret_word[7:0];
        case (state_q)
            ST_ENT_LO: mem_we = 1'b1;
            ST_ENT_HI:
            begin
                mem_we = 1'b1;
                mem_wdata = ret_word[15:8];
            end
            ST_RET_HI, ST_RET_LO:
            begin
                mem_re = 1'b1;
                mem_addr = sp_plus1;
            end
            ST_RUN:
            begin
                if (fetch && exec_op == OP_PUSH)
                begin
                    mem_we = 1'b1;
                    mem_wdata = op_a;
                end
                else if (fetch && exec_op == OP_POP)
                begin
                    mem_re = 1'b1;
                    mem_addr = sp_plus1;
                end
                else if (fetch && (exec_op == OP_LD || exec_op == OP_ST))
                begin
                    mem_addr = eff_addr;
                    mem_re = (exec_op == OP_LD) && !reg_hit;
                    mem_we = (exec_op == OP_ST) && !reg_hit;
                    mem_wdata = op_a;
                end
            end
            default: mem_we = 1'b0;
        endcase
    end

    assign req = ((pend_q & ~LEVEL_MASK) | (irq_level & LEVEL_MASK)) &
                 irq_enable;
    assign win_idx = cs_first(req);
    // A disable in the same cycle, by instruction or by a status write,
    // already counts, so nothing slips in beside it.
    assign gie_now = status_q[FLAG_I] && (exec_op != OP_CLI) &&
                     !(status_we && !status_wdata[FLAG_I]);
    assign suppress = (app_section_lock_bit && !pc_in_boot &&
                       vector_select_bit) ||
                      (boot_section_lock_bit && pc_in_boot &&
                       !vector_select_bit);
    assign take = fetch && gie_now && (|req) && !suppress && !inhibit_q &&
                  (exec_op != OP_SEI) && (exec_op != OP_RETURN_FROM_IRQ_INSTR) &&
                  (exec_op != OP_CALL);
    assign ack = take ? (NUM_IRQ'(1) << win_idx) : '0;

    // Event flags: a new event in the clearing cycle is kept.
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            pend_q <= '0;
        end
        else
        begin
            pend_q <= ((pend_q & ~(irq_flag_clear | ack)) |
                       irq_event) & ~LEVEL_MASK;
        end
    end
    assign irq_pending = pend_q;

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            state_q <= ST_RUN;
        end
        else
        begin
            case (state_q)
                ST_RUN:
                    if (take)
                        state_q <= ST_ENT_LO;
                    else if (fetch && exec_op == OP_RETURN_FROM_IRQ_INSTR)
                        state_q <= ST_RET_HI;
                ST_ENT_LO: state_q <= ST_ENT_HI;
                ST_ENT_HI: state_q <= ST_ENT_W1;
                ST_ENT_W1: state_q <= ST_ENT_VEC;
                ST_ENT_VEC: state_q <= ST_RUN;
                ST_RET_HI: state_q <= ST_RET_LO;
                ST_RET_LO: state_q <= ST_RET_PC;
                ST_RET_PC: state_q <= ST_RUN;
                default: state_q <= ST_RUN;
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            ret_pc_q <= '0;
            vec_q <= '0;
            pop_hi_q <= 8'h00;
            popped_pc_q <= '0;
        end
        else
        begin
            if (take)
            begin
                ret_pc_q <= ret_pc;
                vec_q <= (vector_select_bit ? BOOT_START : '0) +
                         PC_W'((int'(win_idx) + 1) * VEC_WORDS);
            end
            if (state_q == ST_RET_HI)
                pop_hi_q <= mem_rdata;
            if (state_q == ST_RET_LO)
                popped_pc_q <= PC_W'({pop_hi_q, mem_rdata});
        end
    end
    assign pc_load = (state_q == ST_ENT_VEC) || (state_q == ST_RET_PC);
    assign pc_value = (state_q == ST_RET_PC) ? popped_pc_q : vec_q;
    assign reset_vector = boot_reset_fuse ? BOOT_START : '0;

    always_ff @(posedge clock)
    begin
        if (srst)
            inhibit_q <= 1'b0;
        else if (state_q == ST_RET_PC)
            inhibit_q <= 1'b1;
        else if (fetch)
            inhibit_q <= (exec_op == OP_SEI);
    end

    // Stack pointer; an I/O write lands last and wins.
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            sp_q <= SP_RESET;
        end
        else
        begin
            if (state_q == ST_ENT_LO || state_q == ST_ENT_HI)
                sp_q <= sp_q - SP_STEP_ONE;
            else if (state_q == ST_RET_HI || state_q == ST_RET_LO)
                sp_q <= sp_q + SP_STEP_ONE;
            else if (fetch)
            begin
                case (exec_op)
                    OP_PUSH: sp_q <= sp_q - SP_STEP_ONE;
                    OP_POP: sp_q <= sp_q + SP_STEP_ONE;
                    OP_CALL: sp_q <= sp_q - SP_STEP_TWO;
                    OP_RET: sp_q <= sp_q + SP_STEP_TWO;
                    default: sp_q <= sp_q;
                endcase
            end
            if (io_we && io_addr == SP_LOW_IO)
                sp_q[7:0] <= io_wdata;
            if (io_we && io_addr == SP_HIGH_IO)
                sp_q[15:8] <= io_wdata;
        end
    end
    assign io_hit = (io_addr == SP_LOW_IO) || (io_addr == SP_HIGH_IO);
    assign io_rdata = (io_addr == SP_LOW_IO) ? sp_q[7:0] :
                      (io_addr == SP_HIGH_IO) ? sp_q[15:8] : 8'h00;

    // Entry and return touch only the enable flag.
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            status_q <= STATUS_RESET;
        end
        else
        begin
            if (fetch)
            begin
                case (exec_op)
                    OP_ADD, OP_ADC, OP_SUB, OP_SBC:
                    begin
                        status_q[FLAG_C] <= alu.c;
                        status_q[FLAG_V] <= alu.v;
                        status_q[FLAG_H] <= alu.h;
                        status_q[FLAG_N] <= alu.n;
                        status_q[FLAG_Z] <= alu.z;
                    end
                    OP_AND, OP_OR, OP_EOR:
                    begin
                        status_q[FLAG_V] <= 1'b0;
                        status_q[FLAG_N] <= alu.n;
                        status_q[FLAG_Z] <= alu.z;
                    end
                    OP_ADIW:
                    begin
                        status_q[FLAG_C] <= ~adiw_sum[15] & rf.pr_data[15];
                        status_q[FLAG_V] <= adiw_sum[15] & ~rf.pr_data[15];
                        status_q[FLAG_N] <= adiw_sum[15];
                        status_q[FLAG_Z] <= (adiw_sum == 16'h0000);
                    end
                    OP_BST: status_q[FLAG_T] <= op_a[exec_bit];
                    OP_SEI: status_q[FLAG_I] <= 1'b1;
                    OP_CLI: status_q[FLAG_I] <= 1'b0;
                    default: status_q[FLAG_S] <= 1'b0;
                endcase
            end
            if (status_we)
                status_q <= status_wdata;
            if (state_q == ST_RET_PC)
                status_q[FLAG_I] <= 1'b1;
            if (take)
                status_q[FLAG_I] <= 1'b0;
        end
    end
    // The stored sign bit is never read out; it is formed from the other two.
    always_comb
    begin
        status_flags = status_q;
        status_flags[FLAG_S] = status_q[FLAG_N] ^ status_q[FLAG_V];
    end

endmodule : cs_core

// ==== hw/cs_pkg.sv ====
// Shared constants, types and encodings of the CPU core-state block.
// Assumes a single clock domain and an 8-bit data path.
package cs_pkg;

    localparam int REG_COUNT = 32;
    localparam int REG_AW = 5;
    localparam int PAIR_AW = 4;
    localparam logic [15:0] REG_SPACE_TOP = 16'h001f;
    localparam logic [4:0] PTR_FIRST_LOW = 5'h1a;
    localparam logic [4:0] PTR_SECOND_LOW = 5'h1c;
    localparam logic [4:0] PTR_THIRD_LOW = 5'h1e;

    localparam logic [5:0] SP_LOW_IO = 6'h3d;
    localparam logic [5:0] SP_HIGH_IO = 6'h3e;
    localparam int SP_W = 11;
    localparam logic [15:0] SP_RESET = 16'h0000;
    localparam logic [15:0] SP_STEP_ONE = 16'h0001;
    localparam logic [15:0] SP_STEP_TWO = 16'h0002;

    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;
    localparam logic [7:0] STATUS_RESET = 8'h00;

    typedef enum logic [4:0] {
        OP_NOP, OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_AND, OP_OR, OP_EOR,
        OP_LDI, OP_ADIW, OP_MOVW, OP_BST, OP_BLD, OP_SEI, OP_CLI,
        OP_PUSH, OP_POP, OP_CALL, OP_RET, OP_RETURN_FROM_IRQ_INSTR, OP_LD, OP_ST
    } cs_op_e;

    typedef enum logic [1:0] {
        PM_PLAIN, PM_POST_INC, PM_PRE_DEC, PM_DISP
    } cs_ptr_mode_e;

    typedef enum logic [7:0] {
        ST_RUN = 8'h01,
        ST_ENT_LO = 8'h02,
        ST_ENT_HI = 8'h04,
        ST_ENT_W1 = 8'h08,
        ST_ENT_VEC = 8'h10,
        ST_RET_HI = 8'h20,
        ST_RET_LO = 8'h40,
        ST_RET_PC = 8'h80
    } cs_state_e;

    typedef struct packed {
        logic [7:0] res;
        logic c;
        logic h;
        logic v;
        logic n;
        logic z;
    } cs_alu_s;

endpackage : cs_pkg

// ==== hw/cs_rf_if.sv ====
// Connection between the core-state logic and its register file.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
interface cs_rf_if;
    import cs_pkg::*;
    logic [REG_AW-1:0] ra_addr;
    logic [7:0] ra_data;
    logic [REG_AW-1:0] rb_addr;
    logic [7:0] rb_data;
    logic [REG_AW-1:0] ds_addr;
    logic [7:0] ds_data;
    logic [PAIR_AW-1:0] pr_addr;
    logic [15:0] pr_data;
    logic w8_en;
    logic [REG_AW-1:0] w8_addr;
    logic [7:0] w8_data;
    logic w16_en;
    logic [PAIR_AW-1:0] w16_addr;
    logic [15:0] w16_data;

    modport core (
        output ra_addr, rb_addr, ds_addr, pr_addr,
        output w8_en, w8_addr, w8_data, w16_en, w16_addr, w16_data,
        input ra_data, rb_data, ds_data, pr_data
    );
    modport rf (
        input ra_addr, rb_addr, ds_addr, pr_addr,
        input w8_en, w8_addr, w8_data, w16_en, w16_addr, w16_data,
        output ra_data, rb_data, ds_data, pr_data
    );
endinterface : cs_rf_if

// ==== hw/cs_regfile.sv ====
// Thirty-two 8-bit working registers with byte and pair ports.
// Assumes one clock; a byte write beats a pair write.
`timescale 1ns/1ps
module cs_regfile (
    // Clock
    input wire logic clock,
    // Core side
    cs_rf_if.rf port
);
    import cs_pkg::*;

    logic [7:0] regs_q [REG_COUNT];

    // Reads are combinational so an ALU result lands in the same cycle.
    assign port.ra_data = regs_q[port.ra_addr];
    assign port.rb_data = regs_q[port.rb_addr];
    assign port.ds_data = regs_q[port.ds_addr];
    assign port.pr_data = {regs_q[{port.pr_addr, 1'b1}],
                           regs_q[{port.pr_addr, 1'b0}]};

    always_ff @(posedge clock)
    begin
        if (port.w16_en)
        begin
            regs_q[{port.w16_addr, 1'b0}] <= port.w16_data[7:0];
            regs_q[{port.w16_addr, 1'b1}] <= port.w16_data[15:8];
        end
        if (port.w8_en)
        begin
            regs_q[port.w8_addr] <= port.w8_data;
        end
    end

endmodule : cs_regfile

// ==== tb/cs_core_checker.sv ====
// Port assertions for the core-state block.
// Assumes one clock and the synchronous reset srst.
`timescale 1ns/1ps
module cs_core_checker #(parameter int NUM_IRQ = 8) (
    // Clock, reset and instruction port
    input wire logic clock, srst, exec_valid, exec_ready, status_we,
    input wire cs_pkg::cs_op_e exec_op,
    // Results
    input wire logic mem_we, mem_re, pc_load,
    input wire logic [7:0] status_flags,
    input wire logic [NUM_IRQ-1:0] irq_event, irq_pending
);
    import cs_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    wire logic go = exec_valid && exec_ready && !status_we;
    AST_SIGN: assert property (status_flags[4] == ^status_flags[3:2])
        else $error("sign");
    AST_RST: assert property ($past(srst) |-> status_flags == 8'h00)
        else $error("reset");
    AST_ENTRY: assert property ($fell(status_flags[7]) && $past(go)
        && !$past(srst) && $past(exec_op) != OP_CLI |-> mem_we && !exec_ready
        ##1 mem_we ##1 !mem_we ##1 pc_load ##1 exec_ready) else $error("entry");
    AST_GIE: assert property (go && exec_op == OP_NOP && !status_flags[7]
        |=> exec_ready) else $error("gie");
    AST_CLI: assert property (go && exec_op == OP_CLI
        |=> exec_ready && !status_flags[7]) else $error("cli");
    AST_SEI: assert property (go && exec_op == OP_SEI
        |=> status_flags[7] && exec_ready ##1 exec_ready) else $error("sei");
    AST_RETURN_FROM_IRQ_INSTR: assert property (go && exec_op == OP_RETURN_FROM_IRQ_INSTR
        |=> mem_re && !exec_ready ##1 mem_re ##1 pc_load
        ##1 status_flags[7] && exec_ready ##1 exec_ready) else $error("return_from_irq_instr");
    AST_PEND: assert property (|irq_event
        |=> (irq_pending & $past(irq_event)) == $past(irq_event))
        else $error("flag");
endmodule : cs_core_checker
bind cs_core cs_core_checker #(.NUM_IRQ(NUM_IRQ)) u_chk (.clock, .srst,
    .exec_valid, .exec_ready, .status_we, .exec_op, .mem_we, .mem_re,
    .pc_load, .status_flags, .irq_event, .irq_pending);

// ==== tb/cs_mem_model.sv ====
// Data memory beside the core, answering reads in the same cycle.
// Assumes stack addresses fit in 2 KiB.
`timescale 1ns/1ps
module cs_mem_model (
    // Clock
    input wire logic clock,
    // Memory port
    input wire logic [15:0] mem_addr,
    input wire logic mem_we, mem_re,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata
);
    logic [7:0] mem_q [2048];
    logic [7:0] last_q = 8'h00;
    always_ff @(posedge clock)
    begin
        if (mem_we)
            mem_q[mem_addr[10:0]] <= mem_wdata;
        last_q <= mem_rdata;
    end
    // An idle bus toggles so a stale byte is never mistaken for data.
    assign mem_rdata = mem_re ? mem_q[mem_addr[10:0]] : ~last_q;
endmodule : cs_mem_model

// ==== tb/test_cpu_state_and_interrupt_entry.sv ====
// Self-checking bench for the core-state block and its data memory.
// Assumes one 10 MHz clock shared by design and memory model.
`timescale 1ns/1ps
module test_cpu_state_and_interrupt_entry;
    import cs_pkg::*;
    logic clock = '0, srst = '1, exec_valid = '0, io_we = '0, status_we = '0;
    logic pc_in_boot = '0, vector_select_bit = '0, boot_reset_fuse = '0;
    logic app_section_lock_bit = '0, boot_section_lock_bit = '0;
    logic exec_ready, io_hit, mem_we, mem_re, pc_load;
    cs_op_e exec_op = OP_NOP;
    cs_ptr_mode_e exec_ptr_mode = PM_PLAIN;
    logic [4:0] exec_rd = '0, exec_rr = '0;
    logic [2:0] exec_bit = '0;
    logic [1:0] exec_ptr = '0;
    logic [5:0] exec_disp = '0, io_addr = '0;
    logic [7:0] exec_imm = '0, status_wdata = '0, io_wdata = '0, irq_event = '0;
    logic [7:0] irq_level = '0, irq_enable = '0, irq_flag_clear = '0;
    logic [7:0] status_flags, io_rdata, mem_wdata, mem_rdata, irq_pending;
    logic [15:0] mem_addr;
    logic [12:0] ret_pc = '0, pc_value, reset_vector;
    int n_mismatch, n_compared, sp, a, b, s, k;
    bit t, c, z, n, v, h;
    int want[$] = '{3, 5};
    cs_op_e ops[4] = '{OP_PUSH, OP_POP, OP_CALL, OP_RET};
    int dl[4] = '{-1, 1, -2, 2};
    // The boot start is arbitrary, kept clear of wrap-around.
    cs_core #(.BOOT_START(13'h1f00)) u_dut (.*);
    cs_mem_model u_mem (.*);
    initial forever #50 clock = ~clock;
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %0t %h %h", $time, seen, exp);
        end
    endtask : chk
    task automatic run(input cs_op_e op, input logic [4:0] rd = 5'h10,
        input logic [7:0] imm = 8'h00);
        do @(negedge clock); while (exec_ready !== 1'h1);
        @(posedge clock);
        exec_op <= op;
        exec_rd <= rd;
        exec_rr <= rd + 5'h1;
        exec_imm <= imm;
        exec_bit <= imm[2:0];
        {exec_ptr, exec_disp} <= 8'($urandom);
        ret_pc <= 13'($urandom);
        exec_valid <= 1'h1;
        @(posedge clock);
        exec_valid <= 1'h0;
        @(negedge clock);
    endtask : run
    task automatic io(input logic [5:0] ad, input logic [7:0] d, input logic w);
        @(posedge clock);
        {io_addr, io_wdata, io_we} <= {ad, d, w};
        @(posedge clock);
        io_we <= 1'h0;
        @(negedge clock);
    endtask : io
    task automatic spc(input int e);
        io(SP_LOW_IO, 8'h00, 1'h0);
        chk({io_hit, io_rdata}, {1'h1, e[7:0]});
        io(SP_HIGH_IO, 8'h00, 1'h0);
        chk({io_hit, io_rdata}, {1'h1, e[15:8]});
    endtask : spc
    task automatic summarize;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : summarize
    initial
    begin
        void'($urandom(32'h702e));
        boot_reset_fuse <= 1'($urandom);
        repeat (6) @(posedge clock);
        srst <= 1'h0;
        @(negedge clock);
        chk(status_flags, 8'h00);
        chk(reset_vector, boot_reset_fuse ? 13'h1f00 : 13'h0);
        spc(0);
        sp = 32'h400 | ($urandom & 32'hff);
        io(SP_LOW_IO, sp[7:0], 1'h1);
        io(SP_HIGH_IO, sp[15:8], 1'h1);
        spc(sp);
        for (int i = 0; i < 4; i++)
        begin
            a = i ? $urandom & 255 : 128;
            b = i ? $urandom & 255 : 128;
            run(OP_LDI, 5'h10, a[7:0]);
            run(OP_LDI, 5'h11, b[7:0]);
            run(OP_ADD);
            s = a + b;
            {c, n, z} = {s[8], s[7], s[7:0] == 0};
            v = a[7] == b[7] && s[7] != a[7];
            h = a[3:0] + b[3:0] > 15;
            chk(status_flags, {1'h0, t, h, n ^ v, v, n, z, c});
            k = $urandom & 7;
            run(OP_BST, 5'h10, k[7:0]);
            t = s[k];
            chk(status_flags[6], t);
        end
        for (int i = 0; i < 4; i++)
        begin
            run(ops[i]);
            sp += dl[i];
            spc(sp);
        end
        @(posedge clock);
        {irq_enable, irq_event} <= 16'h2828;
        @(posedge clock);
        irq_event <= 8'h00;
        run(OP_SEI);
        chk(irq_pending, 8'h28);
        for (int i = 0; i < 2; i++)
        begin
            run(OP_NOP);
            chk(exec_ready, 1'h1);
            @(posedge clock);
            vector_select_bit <= i[0];
            run(OP_NOP);
            for (k = 0; k < 9 && pc_load !== 1'h1; k++)
                @(negedge clock);
            a = (i ? 32'h1f00 : 0) + (want.pop_front() + 1) * 2;
            chk(pc_value, a[15:0]);
            chk({status_flags[7], irq_pending}, i ? 0 : 8'h20);
            sp -= 2;
            spc(sp);
            b = ret_pc;
            run(OP_RETURN_FROM_IRQ_INSTR);
            repeat (2) @(negedge clock);
            chk({pc_load, pc_value}, {1'h1, b[12:0]});
            sp += 2;
            spc(sp);
        end
        run(OP_NOP);
        @(posedge clock);
        irq_event <= 8'h08;
        @(posedge clock);
        irq_event <= 8'h00;
        run(OP_CLI);
        run(OP_NOP);
        chk({exec_ready, irq_pending}, 9'h108);
        @(posedge clock);
        {irq_flag_clear, status_wdata, status_we} <= 17'h011ff;
        @(posedge clock);
        {irq_flag_clear, status_we} <= 9'h000;
        @(negedge clock);
        chk({irq_pending, status_flags}, 16'h00ef);
        summarize();
    end
    initial
    begin
        #200000;
        n_mismatch++;
        summarize();
    end
endmodule : test_cpu_state_and_interrupt_entry
